// ==== core/piou_unit.v ====
// Functional notes
// - op 84 mod 1: route analog point 000-299 to converter, start conversion.
// - convert: release processor after 160 us; conversion lasts 50 ms.
// - op 86 mod 2: store held result first, then convert new address.
// - result written as four digits from operand address upward.
// - high digit always flagged; low digit flagged when negative; old data lost.
// - over-range previous input stores four flagged zero digits.
// - then address goes to selector; conversion gives 0000-9999.
// - multiplexer busy indicator on through whole 50 ms conversion.
// - with complete-interrupt fitted, interrupt after each conversion.
// - selector busy 12.5 ms after read-and-select; selector users stall.
// - read-and-select frees processor after 240 us for other work.
// - op 86 mod 7: read contact-sense points at address 00-19 to storage.
// - op 86 mod 8: copy manual switches into storage, address ignored.
// - op 84 mod 2: select terminal, close its output contact.
// - op 84 mod 3: select terminal, drive set-point signal.
// - op 46 q11=1 masks; interrupts held pending until unmask.
// - op 46 q11=0 unmasks only when mask instruction caused the state.
// - return resumes main program at the interrupted location.
// - scan reads given address and all higher ones in its half.
// - twenty points packed in seven digits: two, then six of three.
`timescale 1ns/1ps
`include "piou_map.vh"
module piou_unit
(
   clk,
   rstn,
   cmd_valid,
   cmd_op,
   cmd_mod,
   cmd_q11,
   cmd_addr,
   cmd_paddr,
   cmd_ready,
   cpu_release,
   int_pending_in,
   int_branch_addr,
   int_taken,
   int_enable,
   resume_valid,
   resume_addr,
   masked,
   conv_complete_fitted,
   adc_data,
   adc_negative,
   adc_overrange,
   contact_in,
   switch_in,
   sel_addr,
   sel_busy,
   mux_busy,
   conv_start,
   conv_irq,
   contact_close,
   setpoint_drive,
   mem_we,
   mem_addr,
   mem_digit,
   mem_flag
);
   input wire clk;
   input wire rstn;
   input wire cmd_valid;
   input wire [7:0] cmd_op;
   input wire [3:0] cmd_mod;
   input wire cmd_q11;
   input wire [11:0] cmd_addr;
   input wire [19:0] cmd_paddr;
   output reg cmd_ready;
   output reg cpu_release;
   input wire int_pending_in;
   input wire [19:0] int_branch_addr;
   output reg int_taken;
   output reg int_enable;
   output reg resume_valid;
   output reg [19:0] resume_addr;
   output reg masked;
   input wire conv_complete_fitted;
   input wire [15:0] adc_data;
   input wire adc_negative;
   input wire adc_overrange;
   input wire [19:0] contact_in;
   input wire [47:0] switch_in;
   output reg [11:0] sel_addr;
   output reg sel_busy;
   output reg mux_busy;
   output reg conv_start;
   output reg conv_irq;
   output reg contact_close;
   output reg setpoint_drive;
   output reg mem_we;
   output reg [19:0] mem_addr;
   output reg [3:0] mem_digit;
   output reg mem_flag;

   localparam ST_IDLE = 3'd0;
   localparam ST_WAIT_SEL = 3'd1;
   localparam ST_STORE_RES = 3'd2;
   localparam ST_SCAN = 3'd3;
   localparam ST_SWITCH = 3'd4;
   localparam ST_RELEASE = 3'd5;

   // pin inputs, two flops each
   reg [19:0] contact_s1_reg, contact_s2_reg;
   reg [47:0] switch_s1_reg, switch_s2_reg;
   reg [15:0] adc_s1_reg, adc_s2_reg;
   reg neg_s1_reg, neg_s2_reg, ovr_s1_reg, ovr_s2_reg;
   reg fit_s1_reg, fit_s2_reg, irq_s1_reg, irq_s2_reg;

   reg [2:0] state_reg;
   reg [7:0] op_reg;
   reg [3:0] mod_reg;
   reg [11:0] addr_reg;
   reg [19:0] paddr_reg;
   reg [3:0] dig_reg;
   reg [7:0] scan_reg;
   reg [23:0] rel_reg;
   reg [15:0] result_reg;
   reg res_neg_reg, res_ovr_reg;
   reg pend_reg, mask_by_inst_reg, in_int_reg, irq_d_reg;
   wire [3:0] dpos;
   reg [19:0] ret_reg;

   wire conv_busy, conv_done, selt_busy;
   reg conv_load, sel_load;
   wire is_sel_user;
   wire [7:0] half_top;
   wire [2:0] pack;

   piou_timer u_conv
   (
      .clk(clk),
      .rstn(rstn),
      .load(conv_load),
      .count(`PIOU_CONV_CYC),
      .busy(conv_busy),
      .done(conv_done)
   );

   piou_timer u_sel
   (
      .clk(clk),
      .rstn(rstn),
      .load(sel_load),
      .count(`PIOU_SEL_CYC),
      .busy(selt_busy),
      .done()
   );

   assign is_sel_user = (cmd_op == `PIOU_OP_SELECT) ||
      (cmd_op == `PIOU_OP_READ && (cmd_mod == `PIOU_MOD_RESELECT ||
      cmd_mod == `PIOU_MOD_SCAN));
   assign half_top = (scan_reg < `PIOU_HALF_SPLIT) ? `PIOU_HALF_TOP_LO : `PIOU_HALF_TOP_HI;
   // first digit holds points 0-1, later digits three points each
   assign dpos = dig_reg - `PIOU_SCAN_SETTLE;
   assign pack = (dpos == 4'h0) ? {1'b0, contact_s2_reg[0], contact_s2_reg[1]} :
      {contact_s2_reg[dpos*3-1], contact_s2_reg[dpos*3], contact_s2_reg[dpos*3+1]};

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         contact_s1_reg <= 20'h00000;
         contact_s2_reg <= 20'h00000;
         switch_s1_reg <= 48'h000000000000;
         switch_s2_reg <= 48'h000000000000;
         adc_s1_reg <= 16'h0000;
         adc_s2_reg <= 16'h0000;
         neg_s1_reg <= 1'b0;
         neg_s2_reg <= 1'b0;
         ovr_s1_reg <= 1'b0;
         ovr_s2_reg <= 1'b0;
         fit_s1_reg <= 1'b0;
         fit_s2_reg <= 1'b0;
         irq_s1_reg <= 1'b0;
         irq_s2_reg <= 1'b0;
      end
      else
      begin
         contact_s1_reg <= contact_in;
         contact_s2_reg <= contact_s1_reg;
         switch_s1_reg <= switch_in;
         switch_s2_reg <= switch_s1_reg;
         adc_s1_reg <= adc_data;
         adc_s2_reg <= adc_s1_reg;
         neg_s1_reg <= adc_negative;
         neg_s2_reg <= neg_s1_reg;
         ovr_s1_reg <= adc_overrange;
         ovr_s2_reg <= ovr_s1_reg;
         fit_s1_reg <= conv_complete_fitted;
         fit_s2_reg <= fit_s1_reg;
         irq_s1_reg <= int_pending_in;
         irq_s2_reg <= irq_s1_reg;
      end
   end

   always @*
   begin
      conv_load = 1'b0;
      sel_load = 1'b0;
      if (state_reg == ST_WAIT_SEL && !selt_busy && mod_reg == `PIOU_MOD_CONVERT
         && op_reg == `PIOU_OP_SELECT && addr_reg <= `PIOU_ANALOG_MAX)
         conv_load = 1'b1;
      if (state_reg == ST_STORE_RES && dig_reg == 4'h3)
      begin
         conv_load = 1'b1;
         sel_load = 1'b1;
      end
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= ST_IDLE;
         op_reg <= 8'h00;
         mod_reg <= 4'h0;
         addr_reg <= 12'h000;
         paddr_reg <= 20'h00000;
         dig_reg <= 4'h0;
         scan_reg <= 8'h00;
         rel_reg <= 24'h000000;
         result_reg <= 16'h0000;
         res_neg_reg <= 1'b0;
         res_ovr_reg <= 1'b0;
         pend_reg <= 1'b0;
         mask_by_inst_reg <= 1'b0;
         in_int_reg <= 1'b0;
         irq_d_reg <= 1'b0;
         ret_reg <= 20'h00000;
         cmd_ready <= 1'b0;
         cpu_release <= 1'b0;
         int_taken <= 1'b0;
         int_enable <= 1'b1;
         resume_valid <= 1'b0;
         resume_addr <= 20'h00000;
         masked <= 1'b0;
         sel_addr <= 12'h000;
         sel_busy <= 1'b0;
         mux_busy <= 1'b0;
         conv_start <= 1'b0;
         conv_irq <= 1'b0;
         contact_close <= 1'b0;
         setpoint_drive <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 20'h00000;
         mem_digit <= 4'h0;
         mem_flag <= 1'b0;
      end
      else
      begin
         cmd_ready <= 1'b0;
         cpu_release <= 1'b0;
         int_taken <= 1'b0;
         resume_valid <= 1'b0;
         conv_start <= conv_load;
         contact_close <= 1'b0;
         setpoint_drive <= 1'b0;
         mem_we <= 1'b0;
         mux_busy <= conv_busy;
         sel_busy <= selt_busy;
         conv_irq <= conv_done && fit_s2_reg;
         if (conv_done)
         begin
            result_reg <= adc_s2_reg;
            res_neg_reg <= neg_s2_reg;
            res_ovr_reg <= ovr_s2_reg;
         end
         // pending interrupts held while masked; a new request beats delivery
         irq_d_reg <= irq_s2_reg;
         if (pend_reg && !masked && !in_int_reg)
         begin
            pend_reg <= 1'b0;
            int_taken <= 1'b1;
            in_int_reg <= 1'b1;
            ret_reg <= int_branch_addr;
         end
         if (irq_s2_reg && !irq_d_reg)
            pend_reg <= 1'b1;
         int_enable <= !masked;
         case (state_reg)
            ST_IDLE:
            begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready)
               begin
                  cmd_ready <= 1'b0;
                  op_reg <= cmd_op;
                  mod_reg <= cmd_mod;
                  addr_reg <= cmd_addr;
                  paddr_reg <= cmd_paddr;
                  dig_reg <= 4'h0;
                  scan_reg <= cmd_addr[7:0];
                  if (cmd_op == `PIOU_OP_MASK)
                  begin
                     if (cmd_q11)
                     begin
                        masked <= 1'b1;
                        mask_by_inst_reg <= 1'b1;
                     end
                     else if (mask_by_inst_reg)
                     begin
                        masked <= 1'b0;
                        mask_by_inst_reg <= 1'b0;
                     end
                     rel_reg <= 24'h000001;
                     state_reg <= ST_RELEASE;
                  end
                  else if (cmd_op == `PIOU_OP_BRANCH_OUT)
                  begin
                     resume_valid <= in_int_reg;
                     resume_addr <= ret_reg;
                     in_int_reg <= 1'b0;
                     rel_reg <= 24'h000001;
                     state_reg <= ST_RELEASE;
                  end
                  else if (is_sel_user)
                     state_reg <= ST_WAIT_SEL;
                  else if (cmd_op == `PIOU_OP_READ && cmd_mod == `PIOU_MOD_SWITCH)
                     state_reg <= ST_SWITCH;
                  else
                  begin
                     rel_reg <= 24'h000001;
                     state_reg <= ST_RELEASE;
                  end
               end
            end
            ST_WAIT_SEL:
            begin
               if (!selt_busy)
               begin
                  rel_reg <= 24'h000001;
                  state_reg <= ST_RELEASE;
                  if (op_reg == `PIOU_OP_SELECT && addr_reg <= `PIOU_ANALOG_MAX)
                  begin
                     sel_addr <= addr_reg;
                     if (mod_reg == `PIOU_MOD_CONVERT)
                        rel_reg <= `PIOU_SA_REL_CYC;
                     else if (mod_reg == `PIOU_MOD_CLOSE)
                        contact_close <= 1'b1;
                     else if (mod_reg == `PIOU_MOD_SETPOINT)
                        setpoint_drive <= 1'b1;
                  end
                  else if (op_reg == `PIOU_OP_SELECT)
                     state_reg <= ST_RELEASE;
                  else if (mod_reg == `PIOU_MOD_RESELECT && !conv_busy)
                     state_reg <= ST_STORE_RES;
                  else if (mod_reg == `PIOU_MOD_RESELECT)
                     state_reg <= ST_WAIT_SEL;
                  else if (mod_reg == `PIOU_MOD_SCAN && scan_reg <= `PIOU_SCAN_MAX)
                  begin
                     sel_addr <= {4'h0, scan_reg};
                     state_reg <= ST_SCAN;
                  end
               end
            end
            ST_STORE_RES:
            begin
               mem_we <= 1'b1;
               mem_addr <= paddr_reg + {16'h0000, dig_reg};
               mem_digit <= res_ovr_reg ? 4'h0 : result_reg[15 - dig_reg*4 -: 4];
               mem_flag <= (dig_reg == 4'h0) || res_ovr_reg ||
                  (dig_reg == 4'h3 && res_neg_reg);
               dig_reg <= dig_reg + 4'h1;
               if (dig_reg == 4'h3)
               begin
                  sel_addr <= addr_reg;
                  rel_reg <= `PIOU_RESULT_READ_AND_RESELECT_REL_CYC - 24'd4;
                  state_reg <= ST_RELEASE;
               end
            end
            ST_SCAN:
            begin
               // contacts of a new address need two cycles through the synchroniser
               dig_reg <= dig_reg + 4'h1;
               if (dig_reg >= `PIOU_SCAN_SETTLE)
               begin
                  mem_we <= 1'b1;
                  mem_addr <= paddr_reg;
                  mem_digit <= {1'b0, pack};
                  mem_flag <= 1'b0;
                  paddr_reg <= paddr_reg + 20'h00001;
               end
               if (dig_reg == `PIOU_SCAN_LAST)
               begin
                  dig_reg <= 4'h0;
                  if (scan_reg == half_top)
                  begin
                     rel_reg <= 24'h000001;
                     state_reg <= ST_RELEASE;
                  end
                  else if (scan_reg[3:0] == 4'h9)
                  begin
                     scan_reg <= scan_reg + 8'h07;
                     sel_addr <= {4'h0, scan_reg + 8'h07};
                  end
                  else
                  begin
                     scan_reg <= scan_reg + 8'h01;
                     sel_addr <= {4'h0, scan_reg + 8'h01};
                  end
               end
            end
            ST_SWITCH:
            begin
               mem_we <= 1'b1;
               mem_addr <= paddr_reg + {16'h0000, dig_reg};
               mem_digit <= switch_s2_reg[47 - dig_reg*4 -: 4];
               mem_flag <= 1'b0;
               dig_reg <= dig_reg + 4'h1;
               if (dig_reg == `PIOU_SWITCH_DIGITS - 4'd1)
               begin
                  rel_reg <= 24'h000001;
                  state_reg <= ST_RELEASE;
               end
            end
            ST_RELEASE:
            begin
               rel_reg <= rel_reg - 24'h000001;
               if (rel_reg <= 24'h000001)
               begin
                  cpu_release <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // piou_unit

// ==== common/piou_map.vh ====
`ifndef PIOU_MAP_VH
`define PIOU_MAP_VH
// opcodes as bcd pairs, modifiers as single bcd digits
`define PIOU_OP_SELECT 8'h84
`define PIOU_OP_READ 8'h86
`define PIOU_OP_MASK 8'h46
`define PIOU_OP_BRANCH_OUT 8'h47
`define PIOU_MOD_CONVERT 4'h1
`define PIOU_MOD_RESELECT 4'h2
`define PIOU_MOD_CLOSE 4'h2
`define PIOU_MOD_SETPOINT 4'h3
`define PIOU_MOD_SCAN 4'h7
`define PIOU_MOD_SWITCH 4'h8
`define PIOU_MOD_NONE 4'h0
// timing in ns, cycles at 10 ns
`define PIOU_CLK_NS 10
`define PIOU_T_SA_REL_NS 160000
`define PIOU_T_RESULT_READ_AND_RESELECT_REL_NS 240000
`define PIOU_T_CONV_NS 50000000
`define PIOU_T_SEL_NS 12500000
// same spans in clock cycles, sized to the 24-bit counters
`define PIOU_SA_REL_CYC 24'd16000
`define PIOU_RESULT_READ_AND_RESELECT_REL_CYC 24'd24000
`define PIOU_CONV_CYC 24'd5000000
`define PIOU_SEL_CYC 24'd1250000
// scan: two settle cycles after an address change, then seven digits
`define PIOU_SCAN_SETTLE 4'd2
`define PIOU_SCAN_LAST 4'd8
// address limits
`define PIOU_ANALOG_MAX 12'h299
`define PIOU_SCAN_MAX 8'h19
`define PIOU_HALF_SPLIT 8'h10
`define PIOU_HALF_TOP_LO 8'h09
`define PIOU_HALF_TOP_HI 8'h19
// digit storage
`define PIOU_RESULT_DIGITS 3'd4
`define PIOU_GROUP_DIGITS 3'd7
`define PIOU_SWITCH_DIGITS 4'd12
`define PIOU_CNT_W 24
`endif

// ==== core/piou_timer.v ====
`timescale 1ns/1ps
// down counter, busy while non-zero
module piou_timer
(
   clk,
   rstn,
   load,
   count,
   busy,
   done
);
   input wire clk;
   input wire rstn;
   input wire load;
   input wire [23:0] count;
   output reg busy;
   output reg done;
   reg [23:0] cnt_reg;
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg <= 24'h000000;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (load)
         begin
            cnt_reg <= count;
            busy <= 1'b1;
         end
         else if (cnt_reg != 24'h000000)
         begin
            cnt_reg <= cnt_reg - 24'h000001;
            if (cnt_reg == 24'h000001)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // piou_timer

// ==== dv/piou_unit_sva.sv ====
`timescale 1ns/1ps
`include "piou_map.vh"
module piou_unit_sva
(
   input wire clk,
   input wire rstn,
   input wire conv_start,
   input wire conv_irq,
   input wire mux_busy,
   input wire sel_busy,
   input wire [11:0] sel_addr,
   input wire contact_close,
   input wire setpoint_drive,
   input wire masked,
   input wire int_taken,
   input wire int_enable,
   input wire mem_we,
   input wire [19:0] mem_addr
);
   reg [23:0] conv_cnt_reg;
   reg [23:0] sel_cnt_reg;
   // length of the current busy stretches
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         conv_cnt_reg <= 24'h000000;
         sel_cnt_reg <= 24'h000000;
      end
      else
      begin
         conv_cnt_reg <= mux_busy ? conv_cnt_reg + 24'h000001 : 24'h000000;
         sel_cnt_reg <= sel_busy ? sel_cnt_reg + 24'h000001 : 24'h000000;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   chk_conv_full: assert property ($fell(mux_busy) |-> conv_cnt_reg >= `PIOU_CONV_CYC - 2)
      else $error("conversion busy ended early");
   chk_conv_bound: assert property (conv_cnt_reg <= `PIOU_CONV_CYC + 2)
      else $error("conversion busy too long");
   chk_sel_full: assert property ($fell(sel_busy) |-> sel_cnt_reg >= `PIOU_SEL_CYC - 2)
      else $error("selector busy ended early");
   chk_sel_bound: assert property (sel_cnt_reg <= `PIOU_SEL_CYC + 2)
      else $error("selector busy too long");
   chk_start_busy: assert property (conv_start |=> mux_busy [*3])
      else $error("no busy after conversion start");
   chk_start_range: assert property (conv_start |=> sel_addr <= 12'h299)
      else $error("conversion on bad point");
   chk_out_range: assert property (contact_close || setpoint_drive |-> sel_addr <= 12'h299)
      else $error("output on bad point");
   chk_mask_hold: assert property (masked && $past(masked) |-> !int_taken)
      else $error("interrupt taken while masked");
   chk_enable_lag: assert property (1'b1 |=> int_enable == !$past(masked))
      else $error("interrupt enable wrong");
   chk_mem_step: assert property (mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 20'h00001)
      else $error("storage address not ascending");
   chk_irq_end: assert property (conv_irq |-> !mux_busy)
      else $error("complete interrupt during conversion");
endmodule // piou_unit_sva
bind piou_unit piou_unit_sva piou_unit_sva_inst (.clk(clk), .rstn(rstn), .conv_start(conv_start),
   .conv_irq(conv_irq), .mux_busy(mux_busy), .sel_busy(sel_busy), .sel_addr(sel_addr),
   .contact_close(contact_close), .setpoint_drive(setpoint_drive), .masked(masked),
   .int_taken(int_taken), .int_enable(int_enable), .mem_we(mem_we), .mem_addr(mem_addr));

// ==== dv/piou_field.sv ====
`timescale 1ns/1ps
module piou_field
(
   input wire logic clk,
   input wire logic [11:0] sel_addr,
   input wire logic [19:0] contact_seed,
   input wire logic mem_we,
   input wire logic [19:0] mem_addr,
   input wire logic [3:0] mem_digit,
   input wire logic mem_flag,
   output logic [19:0] contact_in,
   output logic [15:0] adc_data
);
   logic [24:0] wr_q[$];
   // each block address shows its own point pattern
   assign contact_in = contact_seed ^ {sel_addr[7:0], sel_addr[7:0], sel_addr[3:0]};
   assign adc_data = 16'h4821;
   always @(posedge clk)
   begin
      if (mem_we === 1'b1)
         wr_q.push_back({mem_addr, mem_digit, mem_flag});
   end
endmodule // piou_field

// ==== dv/tb_piou_unit.sv ====
`timescale 1ns/1ps
`include "piou_map.vh"
module tb_piou_unit;
   logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_q11 = 1'b0, int_pending_in = 1'b0;
   logic [7:0] cmd_op = 8'h00;
   logic [3:0] cmd_mod = 4'h0;
   logic [11:0] cmd_addr = 12'h000;
   logic [19:0] cmd_paddr = 20'h00000, int_branch_addr = 20'h00000, c_seed = 20'h00000;
   logic [47:0] switch_in = 48'h000000000000;
   logic cmd_ready, cpu_release, int_taken, int_enable, resume_valid, masked, sel_busy;
   logic mux_busy, conv_start, conv_irq, contact_close, setpoint_drive, mem_we, mem_flag;
   logic [3:0] mem_digit;
   logic [11:0] sel_addr;
   logic [19:0] resume_addr, mem_addr, contact_in, pa, res_a = 20'h00000;
   logic [15:0] adc_data, lf = 16'h0024;
   logic [24:0] exp_q[$];
   logic [7:0] scan_tab[4] = '{8'h09, 8'h00, 8'h18, 8'h20};
   logic [3:0] op_md[4] = '{4'h2, 4'h3, 4'h2, 4'h3};
   logic [11:0] op_ad[4] = '{12'h299, 12'h000, 12'h300, 12'h945};
   int bad_count = 0, check_count = 0, cyc = 0, t_rel = 0, t_st = 0, t_mem = 0;
   int n_rel = 0, n_start = 0, n_close = 0, n_setp = 0, n_int = 0;

   piou_unit piou_unit_inst (.clk, .rstn, .cmd_valid, .cmd_op, .cmd_mod, .cmd_q11, .cmd_addr,
      .cmd_paddr, .cmd_ready, .cpu_release, .int_pending_in, .int_branch_addr, .int_taken,
      .int_enable, .resume_valid, .resume_addr, .masked, .conv_complete_fitted(1'b1),
      .adc_data, .adc_negative(1'b0), .adc_overrange(1'b0), .contact_in, .switch_in,
      .sel_addr, .sel_busy, .mux_busy, .conv_start, .conv_irq, .contact_close,
      .setpoint_drive, .mem_we, .mem_addr, .mem_digit, .mem_flag);
   piou_field piou_field_inst (.clk, .sel_addr, .contact_seed(c_seed), .mem_we, .mem_addr,
      .mem_digit, .mem_flag, .contact_in, .adc_data);

   initial forever #5 clk = ~clk;

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      n_rel <= n_rel + (cpu_release === 1'b1);
      n_start <= n_start + (conv_start === 1'b1);
      n_close <= n_close + (contact_close === 1'b1);
      n_setp <= n_setp + (setpoint_drive === 1'b1);
      n_int <= n_int + (int_taken === 1'b1);
      if (cpu_release === 1'b1) t_rel <= cyc;
      if (conv_start === 1'b1) t_st <= cyc;
      if (mem_we === 1'b1) t_mem <= cyc;
      if (resume_valid === 1'b1) res_a <= resume_addr;
   end

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic rnd(output logic [19:0] v);
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      v = {lf[3:0], lf};
   endtask

   task automatic offer(input logic [7:0] op, input logic [3:0] md, input logic q,
      input logic [11:0] ad);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_mod <= md;
      cmd_q11 <= q;
      cmd_addr <= ad;
      cmd_paddr <= pa;
   endtask

   // offer, hold until taken, then wait for the processor release
   task automatic issue(input logic [7:0] op, input logic [3:0] md, input logic q,
      input logic [11:0] ad, input int lim);
      int n0;
      offer(op, md, q, ad);
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      n0 = n_rel;
      repeat (lim)
      begin
         @(posedge clk);
         if (n_rel != n0)
            return;
      end
      chk(1'b0, "no processor release");
   endtask

   task automatic cmp_q(input logic [24:0] m);
      chk(piou_field_inst.wr_q.size() == exp_q.size(), "stored digit count");
      foreach (exp_q[i])
         if (i < piou_field_inst.wr_q.size())
            chk((piou_field_inst.wr_q[i] & m) === (exp_q[i] & m), "stored digit");
      exp_q.delete();
      piou_field_inst.wr_q.delete();
   endtask

   task automatic exp_scan(input int a, input logic [19:0] sd, input logic [19:0] p);
      logic [19:0] pt;
      logic [7:0] b;
      for (int i = a; i <= (a < 10 ? 9 : 19); i++)
      begin
         b = 8'((i / 10) * 16 + i % 10);
         pt = sd ^ {b, b, b[3:0]};
         exp_q.push_back({p, 2'b00, pt[0], pt[1], 1'b0});
         p++;
         for (int k = 2; k < 20; k += 3)
         begin
            exp_q.push_back({p, 1'b0, pt[k], pt[k + 1], pt[k + 2], 1'b0});
            p++;
         end
      end
   endtask

   initial
   begin
      #900000;
      bad_count++;
      report_and_stop();
   end

   initial
   begin
      logic [19:0] r1, r2, r3;
      logic [47:0] sw;
      int n, m;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rnd(r1);
      rnd(r2);
      rnd(r3);
      sw = {r1[15:0], r2, r3[11:0]};
      switch_in <= sw;
      pa = r1;
      repeat (3) @(posedge clk);
      issue(`PIOU_OP_READ, `PIOU_MOD_SWITCH, 1'b0, 12'h999, 200);
      for (int i = 0; i < 12; i++)
         exp_q.push_back({r1 + 20'(i), sw[47 - 4 * i -: 4], 1'b0});
      cmp_q(25'h1fffffe);
      foreach (scan_tab[j])
      begin
         rnd(r1);
         rnd(r2);
         c_seed <= r2;
         pa = r1;
         repeat (3) @(posedge clk);
         issue(`PIOU_OP_READ, `PIOU_MOD_SCAN, 1'b0, {4'h0, scan_tab[j]}, 5000);
         n = scan_tab[j][7:4] * 10 + scan_tab[j][3:0];
         if (n <= 19)
            exp_scan(n, r2, r1);
         cmp_q(25'h1ffffff);
      end
      foreach (op_md[j])
      begin
         n = n_close;
         m = n_setp;
         issue(`PIOU_OP_SELECT, op_md[j], 1'b0, op_ad[j], 200);
         r3 = (op_ad[j] <= 12'h299);
         chk(n_close - n == (op_md[j] == 4'h2) * r3, "contact close count");
         chk(n_setp - m == (op_md[j] == 4'h3) * r3, "setpoint count");
         if (r3 == 1)
            chk(sel_addr === op_ad[j], "selected terminal");
      end
      issue(`PIOU_OP_MASK, `PIOU_MOD_NONE, 1'b1, 12'h000, 200);
      chk(masked === 1'b1, "mask state");
      rnd(r1);
      int_branch_addr <= r1;
      int_pending_in <= 1'b1;
      n = n_int;
      repeat (40) @(posedge clk);
      chk(n_int == n, "interrupt while masked");
      issue(`PIOU_OP_MASK, `PIOU_MOD_NONE, 1'b0, 12'h000, 200);
      chk(masked === 1'b0, "unmask state");
      for (int k = 0; k < 30 && n_int == n; k++) @(posedge clk);
      chk(n_int == n + 1, "held interrupt lost");
      int_pending_in <= 1'b0;
      issue(`PIOU_OP_BRANCH_OUT, `PIOU_MOD_NONE, 1'b0, 12'h000, 200);
      chk(res_a === r1, "resume location");
      n = n_start;
      issue(`PIOU_OP_SELECT, `PIOU_MOD_CONVERT, 1'b0, 12'h300, 200);
      chk(n_start == n, "conversion on bad point");
      issue(`PIOU_OP_SELECT, `PIOU_MOD_CONVERT, 1'b0, 12'h123, 17000);
      chk(n_start == n + 1 && sel_addr === 12'h123, "conversion start");
      chk(mux_busy === 1'b1, "busy during conversion");
      chk(t_rel - t_st inside {[15997:16003]}, "convert release time");
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rnd(r1);
      pa = r1;
      n = n_start;
      issue(`PIOU_OP_READ, `PIOU_MOD_RESELECT, 1'b0, 12'h042, 26000);
      for (int i = 0; i < 4; i++)
         exp_q.push_back({r1 + 20'(i), 4'h0, i == 0});
      cmp_q(25'h1ffffe1);
      chk(t_rel - t_mem inside {[23990:24010]}, "reselect release time");
      chk(n_start == n + 1 && sel_addr === 12'h042, "new point selected");
      chk(mux_busy === 1'b1 && sel_busy === 1'b1, "busy after reselect");
      n = n_close;
      offer(`PIOU_OP_SELECT, `PIOU_MOD_CLOSE, 1'b0, 12'h005);
      repeat (3000) @(posedge clk);
      chk(n_close == n && sel_busy === 1'b1, "selector user not stalled");
      report_and_stop();
   end
endmodule // tb_piou_unit
